// file: rtl/oocs_params.svh
// Purpose: Constants of the on/off cycle-skip switch controller.
// Assumes: Included by bare name from the package and the modules.
// Notes:   Analog quantities arrive as digital codes in the units named.
`ifndef OOCS_PARAMS_SVH
`define OOCS_PARAMS_SVH

// -----------------------------------------------------------------------------
// Clock and oscillator
// -----------------------------------------------------------------------------
`define OOCS_CLK_HZ 20000000
`define OOCS_CLK_PER_MHZ 20
`define OOCS_SW_HZ_LOW 44000
`define OOCS_SW_HZ_HIGH 130000
`define OOCS_MAX_DUTY_SIGNAL_PCT 67
`define OOCS_LEB_NS 200

// -----------------------------------------------------------------------------
// Thresholds
// -----------------------------------------------------------------------------
`define OOCS_EN_HI_UA 8'h32
`define OOCS_EN_LO_UA 8'h28
`define OOCS_UV_HI_MV 13'h16a8
`define OOCS_UV_LO_MV 13'h13ec
`define OOCS_LINE_ON_V 10'h00d
`define OOCS_LINE_OFF_V 10'h00c

// -----------------------------------------------------------------------------
// Widths
// -----------------------------------------------------------------------------
`define OOCS_CNT_W 16
`define OOCS_BLANK_W 8

`endif

// file: rtl/oocs_pkg.sv
// Purpose: Types shared by the controller modules.
// Assumes: Constants come from oocs_params.svh.
// Notes:   The controller state is one packed struct.
`include "oocs_params.svh"
`default_nettype none

package oocs_pkg;

    // Cycle state, Gray coded along off, on, done.
    typedef enum logic [1:0]
    {
        OOCS_ST_OFF = 2'b00,
        OOCS_ST_ON = 2'b01,
        OOCS_ST_DONE = 2'b11
    } oocs_state_e;

    // All registered state of the controller.
    typedef struct packed
    {
        logic [`OOCS_CNT_W-1:0] osc_cnt;
        logic [`OOCS_BLANK_W-1:0] blank;
        oocs_state_e st;
        logic skipping;
        logic en_sample;
        logic cycle_start;
        logic max_duty;
        logic gate;
    } oocs_ctrl_s;

endpackage : oocs_pkg

`default_nettype wire

// file: rtl/oocs_sync.sv
// Purpose: Two-flop synchroniser for independent single-bit levels.
// Assumes: Each bit is a level; bits are not related to each other.
// Notes:   The first stage feeds only the second stage.
`include "oocs_params.svh"
`default_nettype none

module oocs_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } oocs_sync_s;

    oocs_sync_s cur;
    oocs_sync_s next_cur;

    // Shift the input through two stages.
    always_comb
    begin
        next_cur.meta = din;
        next_cur.sync = cur.meta;
    end

    // Register the state.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign dout = cur.sync;

endmodule : oocs_sync

`default_nettype wire

// file: rtl/oocs_hyst.sv
// Purpose: Digital comparator with hysteresis on a measured code.
// Assumes: SET_AT is above CLR_BELOW.
// Notes:   The flag sets at or above SET_AT and clears below CLR_BELOW.
`include "oocs_params.svh"
`default_nettype none

module oocs_hyst #(
    parameter int unsigned WIDTH = 8,
    parameter logic [WIDTH-1:0] SET_AT = '1,
    parameter logic [WIDTH-1:0] CLR_BELOW = '0,
    parameter bit RST_VAL = 1'b0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] level,
    output logic flag
);
    typedef struct packed
    {
        logic flag;
    } oocs_hyst_s;

    oocs_hyst_s cur;
    oocs_hyst_s next_cur;

    // The threshold in force depends on the present flag.
    always_comb
    begin
        next_cur = cur;
        if (level >= SET_AT)
        begin
            next_cur.flag = 1'b1;
        end
        else if (level < CLR_BELOW)
        begin
            next_cur.flag = 1'b0;
        end
    end

    // Register the state.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cur.flag <= RST_VAL;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign flag = cur.flag;

    // Level at or above the upper threshold sets the flag.
    chk_hyst_set: assert property (@(posedge sys_clk) disable iff (!resetn)
        (level >= SET_AT) |=> flag)
        else $error("hysteresis flag did not set");

    // Flag holds between thresholds.
    chk_hyst_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        (level < SET_AT) && (level >= CLR_BELOW) |=> $stable(flag))
        else $error("hysteresis flag moved inside band");

endmodule : oocs_hyst

`default_nettype wire

// file: rtl/oocs_ctrl.sv
// Purpose: On/off cycle-skip controller for an off-line power switch.
// Assumes: Inputs are synchronous codes; comparator and thermal bits are levels.
// Notes:   One oscillator cycle per period; decisions at the cycle start only.
//
// Function
// - Oscillator runs always, one cycle boundary per period regardless of switching.
// - Enable is sampled once at each cycle start; that sample decides.
// - Enable asserted runs a switching cycle; deasserted skips and resamples next cycle.
// - An enabled cycle turns the switch on at its beginning.
// - Current-limit trip turns the switch off for the rest of the cycle.
// - Switch is forced off when the maximum duty window ends.
// - A started cycle completes, ignoring enable changes until next sample.
// - Enable threshold has hysteresis: 50 uA, dropping to 40 uA once exceeded.
// - Nominal frequency is 44 kHz, or 130 kHz for the high-power variant.
// - On power-down switching stops near 12 V line, then stays off cleanly.
// - Maximum duty signal is high for 67% of each period.
// - Skipping doubles oscillator frequency, except on the high-power variant.
// - Current limit is ignored for a blanking time after each turn-on.
// - Undervoltage below 5.1 V disables switching until supply reaches 5.8 V.
`include "oocs_params.svh"
`default_nettype none

module oocs_ctrl #(
    parameter bit HIGH_POWER = 1'b0,
    parameter int unsigned LEB_NS = `OOCS_LEB_NS
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] enable_sink_ua,
    input wire logic [12:0] supply_mv,
    input wire logic [9:0] line_volts,
    input wire logic current_limit_trip,
    input wire logic thermal_disable,
    output logic switch_gate,
    output logic cycle_start,
    output logic max_duty_signal,
    output logic skip_active,
    output logic undervoltage
);
    import oocs_pkg::*;

    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------

    // Switching rate of the variant and the derived cycle counts.
    localparam int unsigned SW_HZ = HIGH_POWER ? `OOCS_SW_HZ_HIGH : `OOCS_SW_HZ_LOW;
    localparam int unsigned PERIOD_FULL = `OOCS_CLK_HZ / SW_HZ;
    localparam int unsigned PERIOD_SKIP = HIGH_POWER ? PERIOD_FULL : PERIOD_FULL / 2;
    localparam int unsigned MAX_DUTY_SIGNAL_FULL = PERIOD_FULL * `OOCS_MAX_DUTY_SIGNAL_PCT / 100;
    localparam int unsigned MAX_DUTY_SIGNAL_SKIP = PERIOD_SKIP * `OOCS_MAX_DUTY_SIGNAL_PCT / 100;
    localparam int unsigned LEB_RAW = (LEB_NS * `OOCS_CLK_PER_MHZ + 999) / 1000;
    localparam int unsigned LEB_CYC = (LEB_RAW < 1) ? 1 : LEB_RAW;

    localparam logic [`OOCS_CNT_W-1:0] P_FULL = `OOCS_CNT_W'(PERIOD_FULL);
    localparam logic [`OOCS_CNT_W-1:0] P_SKIP = `OOCS_CNT_W'(PERIOD_SKIP);
    localparam logic [`OOCS_CNT_W-1:0] D_FULL = `OOCS_CNT_W'(MAX_DUTY_SIGNAL_FULL);
    localparam logic [`OOCS_CNT_W-1:0] D_SKIP = `OOCS_CNT_W'(MAX_DUTY_SIGNAL_SKIP);
    localparam logic [`OOCS_BLANK_W-1:0] B_CYC = `OOCS_BLANK_W'(LEB_CYC);

    // -------------------------------------------------------------------------
    // Input conditioning
    // -------------------------------------------------------------------------

    logic en_pulled;
    logic supply_ok;
    logic line_ok;
    logic [2:0] sync_out;
    logic en_pulled_s;
    logic limit_s;
    logic thermal_s;
    logic en_asserted;
    logic disabled;

    // Pull-down current detector; reset as pulled so no cycle starts blind.
    oocs_hyst #(
        .WIDTH(8),
        .SET_AT(`OOCS_EN_HI_UA),
        .CLR_BELOW(`OOCS_EN_LO_UA),
        .RST_VAL(1'b1)
    ) u_en_hyst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .level(enable_sink_ua),
        .flag(en_pulled)
    );

    // Supply monitor with the undervoltage band.
    oocs_hyst #(
        .WIDTH(13),
        .SET_AT(`OOCS_UV_HI_MV),
        .CLR_BELOW(`OOCS_UV_LO_MV),
        .RST_VAL(1'b0)
    ) u_uv_hyst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .level(supply_mv),
        .flag(supply_ok)
    );

    // Line monitor; the small band avoids stray pulses while the line decays.
    oocs_hyst #(
        .WIDTH(10),
        .SET_AT(`OOCS_LINE_ON_V),
        .CLR_BELOW(`OOCS_LINE_OFF_V),
        .RST_VAL(1'b0)
    ) u_line_hyst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .level(line_volts),
        .flag(line_ok)
    );

    // Enable, limit and thermal levels cross into the oscillator clock.
    oocs_sync #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .din({en_pulled, current_limit_trip, thermal_disable}),
        .dout(sync_out)
    );

    // Unpack the synchronised bits and build the disable term.
    assign en_pulled_s = sync_out[2];
    assign limit_s = sync_out[1];
    assign thermal_s = sync_out[0];
    assign en_asserted = ~en_pulled_s;
    assign disabled = ~supply_ok | thermal_s | ~line_ok;

    // -------------------------------------------------------------------------
    // Oscillator and cycle state machine
    // -------------------------------------------------------------------------

    oocs_ctrl_s cur;
    oocs_ctrl_s next_cur;
    logic [`OOCS_CNT_W-1:0] period_cur;
    logic [`OOCS_CNT_W-1:0] max_duty_signal_next;
    logic [`OOCS_CNT_W-1:0] osc_inc;
    logic last_cnt;

    // Period of the running cycle and the wrap point of the counter.
    always_comb
    begin
        period_cur = cur.skipping ? P_SKIP : P_FULL;
        osc_inc = cur.osc_cnt + `OOCS_CNT_W'(1);
        last_cnt = (osc_inc >= period_cur);
    end

    // Next-state logic; a decision is taken only at the cycle boundary.
    always_comb
    begin
        next_cur = cur;
        next_cur.cycle_start = 1'b0;
        max_duty_signal_next = D_FULL;
        if (last_cnt)
        begin
            // Cycle boundary: sample enable once and choose on or skip.
            next_cur.osc_cnt = '0;
            next_cur.cycle_start = 1'b1;
            next_cur.en_sample = en_asserted;
            next_cur.skipping = ~en_asserted;
            next_cur.blank = B_CYC;
            if (en_asserted && !disabled)
            begin
                next_cur.st = OOCS_ST_ON;
            end
            else
            begin
                next_cur.st = OOCS_ST_OFF;
            end
        end
        else
        begin
            next_cur.osc_cnt = osc_inc;
            case (cur.st)
                OOCS_ST_ON:
                begin
                    if (cur.blank != '0)
                    begin
                        next_cur.blank = cur.blank - `OOCS_BLANK_W'(1);
                    end
                    // Enable is not looked at here, so the cycle completes.
                    if (disabled)
                    begin
                        next_cur.st = OOCS_ST_DONE;
                    end
                    else if (limit_s && (cur.blank == '0))
                    begin
                        next_cur.st = OOCS_ST_DONE;
                    end
                    else
                    begin
                        next_cur.st = OOCS_ST_ON;
                    end
                end
                OOCS_ST_OFF:
                begin
                    next_cur.st = OOCS_ST_OFF;
                end
                OOCS_ST_DONE:
                begin
                    next_cur.st = OOCS_ST_DONE;
                end
                default:
                begin
                    next_cur.st = OOCS_ST_OFF;
                end
            endcase
        end
        // Duty window of the cycle now running, from its own period.
        max_duty_signal_next = next_cur.skipping ? D_SKIP : D_FULL;
        next_cur.max_duty = (next_cur.osc_cnt < max_duty_signal_next);
        if ((next_cur.st == OOCS_ST_ON) && !next_cur.max_duty)
        begin
            next_cur.st = OOCS_ST_DONE;
        end
        next_cur.gate = (next_cur.st == OOCS_ST_ON) && !disabled;
    end

    // Register the state; the gate resets off.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // Outputs straight from flip-flops; undervoltage is the inverted supply flag.
    assign switch_gate = cur.gate;
    assign cycle_start = cur.cycle_start;
    assign max_duty_signal = cur.max_duty;
    assign skip_active = cur.skipping;
    assign undervoltage = ~supply_ok;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------

    // The counter never passes the full period.
    chk_osc_bound: assert property (@(posedge sys_clk) disable iff (!resetn)
        cur.osc_cnt < P_FULL)
        else $error("oscillator counter out of range");

    // Two cycle starts are never adjacent.
    chk_osc_runs: assert property (@(posedge sys_clk) disable iff (!resetn)
        cycle_start |=> !cycle_start ##1 !cycle_start)
        else $error("cycle start repeated too soon");

    // The enable sample changes only at a cycle start.
    chk_sample_once: assert property (@(posedge sys_clk) disable iff (!resetn)
        !cycle_start |-> $stable(cur.en_sample))
        else $error("enable sampled mid cycle");

    // A skipped cycle keeps the switch off.
    chk_skip_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        cycle_start && !cur.en_sample |-> !switch_gate && skip_active)
        else $error("switch on in a skipped cycle");

    // An enabled cycle turns on with its start.
    chk_start_on: assert property (@(posedge sys_clk) disable iff (!resetn)
        cycle_start && cur.en_sample && !$past(disabled) |-> switch_gate)
        else $error("enabled cycle did not turn on");

    // A trip after blanking ends conduction on the next edge.
    chk_limit_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        switch_gate && limit_s && (cur.blank == '0) && !last_cnt |=> !switch_gate)
        else $error("current limit did not end the pulse");

    // Conduction lies inside the duty window.
    chk_max_duty_signal_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        !max_duty_signal |-> !switch_gate)
        else $error("switch on outside duty window");

    // With no stop condition the pulse continues whatever enable does.
    chk_hold_cycle: assert property (@(posedge sys_clk) disable iff (!resetn)
        switch_gate && !limit_s && !disabled && !last_cnt
        && (osc_inc < (cur.skipping ? D_SKIP : D_FULL)) |=> switch_gate)
        else $error("pulse ended early");

    // Turn-on spikes cannot end the pulse at once.
    chk_blank_ignore: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(switch_gate) && !disabled && (osc_inc < D_SKIP) |=> switch_gate || $past(disabled))
        else $error("pulse ended inside blanking");

    // Any disable holds the gate off from the next edge.
    chk_disable_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        disabled |=> !switch_gate)
        else $error("gate on while disabled");

    // Skipped cycles run at the skip period, which is shortened except on the high-power variant.
    chk_skip_period: assert property (@(posedge sys_clk) disable iff (!resetn)
        skip_active |-> cur.osc_cnt < P_SKIP)
        else $error("skip period too long");

endmodule : oocs_ctrl

`default_nettype wire

// file: tb/oocs_fb_model.sv
// Purpose: Secondary-side feedback loop that drives the enable sink current.
// Assumes: The output voltage is a plain charge count fed by switch pulses.
// Notes:   In manual mode the bench sets the sink current itself.
`default_nettype none

module oocs_fb_model (
    input wire logic sys_clk,
    input wire logic switch_gate,
    input wire logic manual,
    input wire logic [7:0] manual_ua,
    output logic [7:0] enable_sink_ua
);
    timeunit 1ns;
    timeprecision 1ns;

    int vout = 0;

    // The output rests at zero while the bench drives the sink, so the closed loop starts from a known level.
    // Otherwise each clock of conduction adds charge and the load drains one unit per clock.
    always @(negedge sys_clk)
    begin
        vout <= manual ? 0 : vout + (switch_gate ? 3 : 0) - 1;
    end

    // Pull the enable line low while the output sits above its reference.
    assign enable_sink_ua = manual ? manual_ua : ((vout > 400) ? 8'h3c : 8'h0a);

endmodule : oocs_fb_model

`default_nettype wire

// file: tb/oocs_ctrl_tb_top.sv
// Purpose: Self-checking bench for the cycle-skip switch controller.
// Assumes: Inputs change on the falling edge; outputs are read there too.
// Notes:   Both frequency variants run side by side on the same inputs.
`include "oocs_params.svh"
`default_nettype none

`define CHK(got, exp) \
    begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module oocs_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic manual = 1'b1;
    logic [7:0] man_ua = 8'h00;
    logic [12:0] supply_mv = `OOCS_UV_HI_MV;
    logic [9:0] line_volts = 10'h0e6;
    logic trip = 1'b0;
    logic thermal = 1'b0;
    wire logic [7:0] en_ua;
    logic gate, cstart, maxd, skp, uv, hp_start, hp_maxd, hp_gate, hp_skp;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int per, on_w, dm_w, tr, n_on, n_sk;
    logic sk;
    logic [7:0] ua;
    bit pulled;
    logic [31:0] seed = 32'h0000004c;
    // Sink levels in uA and trip positions; -1 means no trip in that cycle.
    logic [7:0] ua_tab [13] = '{8'h00, 8'h2d, 8'h3c, 8'h2d, 8'h31, 8'h27, 8'h32, 8'h28,
                                8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int tr_tab [13] = '{-1, -1, 20, -1, -1, -1, -1, -1, -1, 0, 300, 302, -1};

    // -------------------------------------------------------------------------
    // Clock, design and partner
    // -------------------------------------------------------------------------
    // The clock toggles every half period of 25 ns.
    always #25 sys_clk = ~sys_clk;

    oocs_ctrl i_oocs_ctrl (.sys_clk(sys_clk), .resetn(resetn), .enable_sink_ua(en_ua),
        .supply_mv(supply_mv), .line_volts(line_volts), .current_limit_trip(trip),
        .thermal_disable(thermal), .switch_gate(gate), .cycle_start(cstart),
        .max_duty_signal(maxd), .skip_active(skp), .undervoltage(uv));
    oocs_ctrl #(.HIGH_POWER(1'b1)) i_oocs_ctrl_hp (.sys_clk(sys_clk), .resetn(resetn),
        .enable_sink_ua(en_ua), .supply_mv(supply_mv), .line_volts(line_volts),
        .current_limit_trip(trip), .thermal_disable(thermal), .switch_gate(hp_gate),
        .cycle_start(hp_start), .max_duty_signal(hp_maxd), .skip_active(hp_skp), .undervoltage());
    oocs_fb_model i_oocs_fb_model (.sys_clk(sys_clk), .switch_gate(gate), .manual(manual),
        .manual_ua(man_ua), .enable_sink_ua(en_ua));

    // -------------------------------------------------------------------------
    // Expectations and helpers
    // -------------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Period of one oscillator cycle; a skipped cycle is halved on the low-power variant.
    function automatic int exp_per(input bit hp, input bit en);
        int p;
        p = `OOCS_CLK_HZ / (hp ? `OOCS_SW_HZ_HIGH : `OOCS_SW_HZ_LOW);
        return (hp || en) ? p : p / 2;
    endfunction : exp_per

    function automatic int exp_win(input int p);
        return p * `OOCS_MAX_DUTY_SIGNAL_PCT / 100;
    endfunction : exp_win

    // Enable detector: pulled at 50 uA and above, released below 40 uA, else held.
    function automatic bit pulled_next(input bit p, input logic [7:0] u);
        return (u >= `OOCS_EN_HI_UA) ? 1'b1 : ((u < `OOCS_EN_LO_UA) ? 1'b0 : p);
    endfunction : pulled_next

    task automatic conclude();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic sync_start();
        int n;
        n = 0;
        @(negedge sys_clk);
        while (cstart !== 1'b1 && n < 1000)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask : sync_start

    // Runs from one cycle start to the next, setting the sink for the next decision.
    task automatic run_cycle(input logic [7:0] u, input int t, output int p, output int o,
                             output int d, output logic s);
        p = 0;
        o = 0;
        d = 0;
        s = skp;
        do
        begin
            o += (gate === 1'b1);
            d += (maxd === 1'b1);
            if (p == 1) man_ua = u;
            if (p == t) trip = 1'b1;
            p++;
            @(negedge sys_clk);
        end
        while (cstart !== 1'b1 && p < 1000);
        trip = 1'b0;
    endtask : run_cycle

    task automatic check_cycle(input bit en, input logic [7:0] u, input int t);
        int w;
        run_cycle(u, t, per, on_w, dm_w, sk);
        w = exp_win(exp_per(1'b0, en));
        `CHK(per, exp_per(1'b0, en))
        `CHK(dm_w, w)
        `CHK(sk, !en)
        if (!en)
            `CHK(on_w, 0)
        else if (t == 0)
            `CHK(on_w inside {[4:6]}, 1'b1)
        else if (t > 0)
            `CHK(on_w, (t + 3 < w) ? t + 3 : w)
        else
            `CHK(on_w, w)
    endtask : check_cycle

    task automatic hp_cycle(output int p, output int d, output int o);
        p = 0;
        d = 0;
        o = 0;
        while (hp_start !== 1'b1 && p < 1000)
        begin
            @(negedge sys_clk);
            p++;
        end
        p = 0;
        do
        begin
            d += (hp_maxd === 1'b1);
            o += (hp_gate === 1'b1);
            p++;
            @(negedge sys_clk);
        end
        while (hp_start !== 1'b1 && p < 1000);
    endtask : hp_cycle

    // Selects thermal (0), supply (1) or line (2) as the disable source.
    task automatic set_dis(input int k, input bit on);
        if (k == 0) thermal = on;
        if (k == 1) supply_mv = on ? 13'h1388 : `OOCS_UV_HI_MV;
        if (k == 2) line_volts = on ? 10'h00b : 10'h0e6;
    endtask : set_dis

    // Cuts a hung run short and reports it as a mismatch.
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            error_cnt++;
            conclude();
        end
    end

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial
    begin
        repeat (2) @(negedge sys_clk);
        `CHK(uv, 1'b1)
        `CHK({gate, cstart, maxd, skp}, 4'h0)
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        sync_start();
        pulled = 1'b0;
        // Hysteresis walk and boundary trips, then random sink levels and trips.
        foreach (tr_tab[i])
        begin
            check_cycle(!pulled, ua_tab[i], tr_tab[i]);
            pulled = pulled_next(pulled, ua_tab[i]);
        end
        repeat (24)
        begin
            seed = xs(seed);
            ua = 8'(seed[7:0] % 80);
            tr = (seed[9:8] == 2'b00) ? -1 : 8 + int'(seed[17:10]) % 240;
            check_cycle(!pulled, ua, tr);
            pulled = pulled_next(pulled, ua);
        end
        check_cycle(!pulled, 8'h00, -1);
        // Each disable source ends the pulse, blocks a whole cycle and then recovers.
        for (int k = 0; k < 3; k++)
        begin
            repeat (20) @(negedge sys_clk);
            set_dis(k, 1'b1);
            repeat (4) @(negedge sys_clk);
            `CHK(gate, 1'b0)
            sync_start();
            run_cycle(8'h00, -1, per, on_w, dm_w, sk);
            `CHK(on_w, 0)
            `CHK(per, exp_per(1'b0, 1'b1))
            `CHK(sk, 1'b0)
            set_dis(k, 1'b0);
            sync_start();
            check_cycle(1'b1, 8'h00, -1);
        end
        // A supply inside the band keeps the present undervoltage state.
        supply_mv = 13'h157c;
        repeat (3) @(negedge sys_clk);
        `CHK(uv, 1'b0)
        set_dis(1, 1'b1);
        repeat (3) @(negedge sys_clk);
        supply_mv = 13'h157c;
        repeat (3) @(negedge sys_clk);
        `CHK(uv, 1'b1)
        set_dis(1, 1'b0);
        // The high-power variant keeps its period whether or not it skips.
        for (int k = 0; k < 2; k++)
        begin
            man_ua = k ? 8'h3c : 8'h00;
            repeat (2) hp_cycle(per, dm_w, on_w);
            `CHK(per, exp_per(1'b1, k == 0))
            `CHK(dm_w, exp_win(exp_per(1'b1, 1'b1)))
            `CHK(on_w, k ? 0 : exp_win(exp_per(1'b1, 1'b1)))
            `CHK(hp_skp, 1'(k))
        end
        // Closed loop with the feedback model in charge of the enable.
        manual = 1'b0;
        sync_start();
        n_on = 0;
        n_sk = 0;
        repeat (30)
        begin
            run_cycle(8'h00, -1, per, on_w, dm_w, sk);
            `CHK(per, exp_per(1'b0, on_w != 0))
            `CHK(sk, on_w == 0)
            `CHK(on_w == 0 || on_w == exp_win(454), 1'b1)
            if (on_w != 0) n_on++;
            else n_sk++;
        end
        `CHK(n_on > 0 && n_sk > 0, 1'b1)
        conclude();
    end

endmodule : oocs_ctrl_tb_top

`default_nettype wire
